// file: design/tdf_defs.svh
/*
  Constants of the flow-meter TDC command core: opcodes, register
  indices, field positions, status bits and timing figures.
  Assumes a 20 MHz core clock; included by bare name.
*/
`ifndef TDF_DEFS_SVH
`define TDF_DEFS_SVH

// Opcodes
`define TDF_OP_RESET 8'h50
`define TDF_OP_CAL 8'h03
`define TDF_OP_TEMP 8'h02
`define TDF_OP_INIT 8'h70
`define TDF_OP_TOF_ALT 8'h05
`define TDF_OP_WRITE 4'h8
`define TDF_OP_RD_RES 6'h2C
`define TDF_OP_RD_STAT 8'hB4
`define TDF_OP_RD_PW 8'hB8

// Register indices and reset value
`define TDF_REG_ANALOG 3'h4
`define TDF_REG_FIRE 3'h5
`define TDF_REG_TIMING 3'h6
`define TDF_CFG_RST 32'h0000_0000

// analog_offset_config fields
`define TDF_COMPARATOR_OFFSET_CODE_MSB 12
`define TDF_COMPARATOR_OFFSET_CODE_LSB 8
`define TDF_NEG_RNG 13
`define TDF_POS_RNG 14
`define TDF_WIDTH_EDGE_SELECT 28
`define TDF_COMPARATOR_OFFSET_CODE_STEP_MV 8'h14

// fire_control_config fields
`define TDF_ONFIRE_MSB 30
`define TDF_ONFIRE_LSB 29
`define TDF_ONFIRE_DOWN 2'h2

// analog_timing_config fields
`define TDF_ANALOG_EN 31
`define TDF_TW2_MSB 23
`define TDF_TW2_LSB 22
`define TDF_INT_MSB 21
`define TDF_INT_LSB 18
`define TDF_SETTLE_MSB 17
`define TDF_SETTLE_LSB 16
`define TDF_MAINS_BASE_SELECT 15
`define TDF_FIRE_IDLE_DEFAULT 14
`define TDF_QUAD 13
`define TDF_TIMO_MSB 11
`define TDF_TIMO_LSB 10

// Interrupt source bits within the mask field
`define TDF_INT_TMO 0
`define TDF_INT_ALU 2

// Status word bits
`define TDF_ST_DIR 3
`define TDF_ST_TOF_TMO 9
`define TDF_ST_TEMP_TMO 11
`define TDF_ST_CAL_TMO 12

// Timing
`define TDF_CLK_KHZ 20000
`define TDF_SETTLE_UNIT_US 240
`define TDF_CHARGE_UNIT_US 100
`define TDF_TIMO_UNIT_US 128
`define TDF_SETTLE_UNIT_CYC (`TDF_SETTLE_UNIT_US * `TDF_CLK_KHZ / 1000)
`define TDF_CHARGE_UNIT_CYC (`TDF_CHARGE_UNIT_US * `TDF_CLK_KHZ / 1000)
`define TDF_TIMO_UNIT_CYC (`TDF_TIMO_UNIT_US * `TDF_CLK_KHZ / 1000)

`endif

// file: design/tdf_pkg.sv
/*
  Types of the flow-meter TDC command core.
  Assumes nothing beyond the header of constants.
*/
package tdf_pkg;
  typedef enum logic [2:0] {
    TDF_IDLE = 3'h0,
    TDF_SETTLE = 3'h1,
    TDF_CHARGE = 3'h3,
    TDF_MEASURE = 3'h2,
    TDF_DONE = 3'h6
  } tdf_state_t;

  typedef enum logic [1:0] {
    TDF_K_CAL = 2'h0,
    TDF_K_TEMP = 2'h1,
    TDF_K_TOF = 2'h2
  } tdf_kind_t;
endpackage : tdf_pkg

// file: design/tdf_byte_if.sv
/*
  Byte carrier between the serial shift engine and the command core.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface tdf_byte_if;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic frame_active;
  logic tx_load;
  logic [31:0] tx_word;

  modport engine (output rx_valid, output rx_byte, output frame_active,
                  input tx_load, input tx_word);
  modport core (input rx_valid, input rx_byte, input frame_active,
                output tx_load, output tx_word);
endinterface : tdf_byte_if

// file: design/tdf_spi_shift.sv
/*
  Serial shift engine, clock idle low, data sampled on the falling
  and shifted on the rising serial clock edge, MSB first.
  Assumes pins synchronous to ref_clk_i and each serial clock half
  period at least two ref_clk_i cycles long.
*/
`timescale 1ns/10ps
module tdf_spi_shift
  import tdf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic ssn_i,
  input wire logic mosi_i,
  output logic miso_o,
  tdf_byte_if.engine bus
);
  logic sclk_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic [31:0] tx_sh_reg;
  logic rx_valid_reg;
  logic [7:0] rx_byte_reg;
  logic rise;
  logic fall;

  assign rise = sclk_i && !sclk_reg;
  assign fall = !sclk_i && sclk_reg;
  assign bus.rx_valid = rx_valid_reg;
  assign bus.rx_byte = rx_byte_reg;
  assign bus.frame_active = !ssn_i;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sclk_reg <= 1'b0;
    end else if (ce_i) begin
      sclk_reg <= sclk_i;
    end
  end

  // Byte assembly
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
      rx_valid_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
    end else if (ce_i) begin
      rx_valid_reg <= 1'b0;
      if (ssn_i) begin
        bit_cnt_reg <= 3'h0;
      end else if (fall) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_sh_reg <= {rx_sh_reg[5:0], mosi_i};
        if (bit_cnt_reg == 3'h7) begin
          rx_valid_reg <= 1'b1;
          rx_byte_reg <= {rx_sh_reg, mosi_i};
        end
      end
    end
  end

  // Answer shifting
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      tx_sh_reg <= 32'h0000_0000;
      miso_o <= 1'b0;
    end else if (ce_i) begin
      if (bus.tx_load) begin
        tx_sh_reg <= bus.tx_word;
      end else if (!ssn_i && rise) begin
        miso_o <= tx_sh_reg[31];
        tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
      end
    end
  end
endmodule : tdf_spi_shift

// file: design/tdf_flow_core.sv
/*
  Command interpreter and measurement sequencer of an ultrasonic
  flow-meter TDC, reached through its 4-wire serial port.
  Assumes the analog front end reports each stop hit on hit_valid_i
  with its processed value, and that the host drives the port pins
  synchronous to ref_clk_i.
*/
// Notes on behaviour
// RL1: Opcode 03h runs resonator calibration; completion pulls the interrupt line low.
// RL2: After calibration, opcode B0h reads result word zero holding the measured value.
// RL3: Opcode 02h runs temperature measurement; completion pulls the interrupt line low.
// RL4: Opcode B4h reads status; bits under 1E00h flag temperature errors.
// RL5: Opcodes B0h to B3h read the four temperature result words.
// RL6: Opcode 70h arms the converter; a flight measurement needs that arming.
// RL7: Opcode 05h starts alternating up and down flight measurements.
// RL8: Host waits for the low interrupt line before reading each result.
// RL9: Status bits under 0600h flag a flight timeout, meaning no echo.
// RL10: The processed flight result is read from result word three.
// RL11: Opcode B8h reads the first-wave width ratio; below 0.3 means weak.
// RL12: Fire select value 2 fires down first, so alternation starts downstream.
// RL13: Offset is signed code in mV, plus 20 mV positive range, minus negative.
// RL14: Width edge select zero measures first-wave width on the rising edge.
// RL15: High-pass charge field 3 waits 300 us before measuring.
// RL16: Interrupt mask 1101b enables timeout, arithmetic done and memory end; the core has no memory end source and ignores mask bit 3.
// RL17: Oscillator settle field 2 waits 480 us before measuring.
// RL18: Mains base select zero bases cycle timing on 50 Hz.
// RL19: Fire idle default must be one while the analog input is used.
// RL20: Finest bin select one picks the roughly 23 ps bin.
// RL21: Calibration data stays readable after the next regular measurement.
// RL22: With 512 us temperature cycle, timeout select must be 2 ms.
`timescale 1ns/10ps
`include "tdf_defs.svh"
module tdf_flow_core
  import tdf_pkg::*;
#(
  parameter int SETTLE_UNIT_CYC = `TDF_SETTLE_UNIT_CYC,
  parameter int CHARGE_UNIT_CYC = `TDF_CHARGE_UNIT_CYC,
  parameter int TIMO_UNIT_CYC = `TDF_TIMO_UNIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic spi_sclk_i,
  input wire logic spi_ssn_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic hit_valid_i,
  input wire logic [31:0] hit_data_i,
  input wire logic [7:0] width_ratio_i,
  output logic irq_line_low_o,
  output logic fire_up_o,
  output logic fire_down_o,
  output logic fire_idle_default_o,
  output logic analog_enable_o,
  output logic [7:0] comp_offset_mv_o,
  output logic width_edge_select_o,
  output logic mains_base_select_o,
  output logic finest_bin_select_o
);
  tdf_byte_if bus ();
  tdf_state_t state_reg;
  tdf_kind_t kind_reg;
  logic [2:0] byte_cnt_reg;
  logic [2:0] wr_idx_reg;
  logic [23:0] wr_data_reg;
  logic [31:0] analog_offset_config_reg;
  logic [31:0] fire_control_config_reg;
  logic [31:0] analog_timing_config_reg;
  logic [23:0] wait_cnt_reg;
  logic [2:0] hit_cnt_reg;
  logic armed_reg;
  logic alt_mode_reg;
  logic dir_up_reg;
  logic tmo_reg;
  logic [31:0] res_reg [4];
  logic [7:0] pw_reg;
  logic [15:0] status_reg;
  logic [7:0] op;
  logic cmd_valid;
  logic soft_rst;
  logic wr_strobe;
  logic [31:0] wr_word;
  logic start_cal;
  logic start_temp;
  logic start_tof;
  logic first_up;
  logic [23:0] settle_cyc;
  logic [23:0] charge_cyc;
  logic [23:0] timo_cyc;
  logic [2:0] need_hits;
  logic ev_alu;
  logic ev_tmo;
  logic irq_set;
  logic [3:0] int_mask;
  logic [7:0] offset_calc;

  tdf_spi_shift u_shift (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .sclk_i(spi_sclk_i),
    .ssn_i(spi_ssn_i),
    .mosi_i(spi_mosi_i),
    .miso_o(spi_miso_o),
    .bus(bus.engine)
  );

  // Command decode
  assign op = bus.rx_byte;
  assign cmd_valid = bus.rx_valid && byte_cnt_reg == 3'h0;
  assign soft_rst = cmd_valid && op == `TDF_OP_RESET;
  assign wr_strobe = bus.rx_valid && byte_cnt_reg == 3'h4;
  assign wr_word = {wr_data_reg, op};
  assign start_cal = cmd_valid && op == `TDF_OP_CAL && state_reg == TDF_IDLE; // RL1
  assign start_temp = cmd_valid && op == `TDF_OP_TEMP && state_reg == TDF_IDLE; // RL3
  assign start_tof = cmd_valid && state_reg == TDF_IDLE
    && (armed_reg || op == `TDF_OP_INIT) // RL6
    && (op == `TDF_OP_TOF_ALT || (op == `TDF_OP_INIT && alt_mode_reg)); // RL7
  assign first_up = fire_control_config_reg[`TDF_ONFIRE_MSB:`TDF_ONFIRE_LSB]
    != `TDF_ONFIRE_DOWN; // RL12
  assign int_mask = analog_timing_config_reg[`TDF_INT_MSB:`TDF_INT_LSB];
  assign ev_alu = state_reg == TDF_DONE && !tmo_reg;
  assign ev_tmo = state_reg == TDF_DONE && tmo_reg;
  assign irq_set = (ev_alu && int_mask[`TDF_INT_ALU]) || (ev_tmo && int_mask[`TDF_INT_TMO]); // RL16

  // Wait lengths from the timing fields
  always_comb begin
    case (analog_timing_config_reg[`TDF_SETTLE_MSB:`TDF_SETTLE_LSB]) // RL17
      2'h0: settle_cyc = 24'h00_0000;
      2'h1: settle_cyc = 24'(SETTLE_UNIT_CYC);
      2'h2: settle_cyc = 24'(SETTLE_UNIT_CYC * 2);
      default: settle_cyc = 24'(SETTLE_UNIT_CYC * 4);
    endcase
    charge_cyc = 24'(CHARGE_UNIT_CYC *
      int'(analog_timing_config_reg[`TDF_TW2_MSB:`TDF_TW2_LSB])); // RL15
    timo_cyc = 24'(TIMO_UNIT_CYC) << {analog_timing_config_reg[`TDF_TIMO_MSB:`TDF_TIMO_LSB],
      1'b0}; // RL22
    case (kind_reg)
      TDF_K_TEMP: need_hits = 3'h4;
      default: need_hits = 3'h1;
    endcase
  end

  assign offset_calc = {{3{analog_offset_config_reg[`TDF_COMPARATOR_OFFSET_CODE_MSB]}},
      analog_offset_config_reg[`TDF_COMPARATOR_OFFSET_CODE_MSB:`TDF_COMPARATOR_OFFSET_CODE_LSB]}
    + (analog_offset_config_reg[`TDF_POS_RNG] ? `TDF_COMPARATOR_OFFSET_CODE_STEP_MV : 8'h00)
    - (analog_offset_config_reg[`TDF_NEG_RNG] ? `TDF_COMPARATOR_OFFSET_CODE_STEP_MV : 8'h00); // RL13

  // Byte position within a frame
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      byte_cnt_reg <= 3'h0;
      wr_idx_reg <= 3'h0;
      wr_data_reg <= 24'h00_0000;
    end else if (ce_i) begin
      if (!bus.frame_active) begin
        byte_cnt_reg <= 3'h0;
      end else if (bus.rx_valid) begin
        if (byte_cnt_reg == 3'h0) begin
          if (op[7:4] == `TDF_OP_WRITE) begin
            byte_cnt_reg <= 3'h1;
            wr_idx_reg <= op[2:0];
          end
        end else begin
          wr_data_reg <= {wr_data_reg[15:0], op};
          byte_cnt_reg <= (byte_cnt_reg == 3'h4) ? 3'h0 : byte_cnt_reg + 3'h1;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || (ce_i && soft_rst)) begin
      analog_offset_config_reg <= `TDF_CFG_RST;
      fire_control_config_reg <= `TDF_CFG_RST;
      analog_timing_config_reg <= `TDF_CFG_RST;
    end else if (ce_i && wr_strobe) begin
      if (wr_idx_reg == `TDF_REG_ANALOG) begin
        analog_offset_config_reg <= wr_word;
      end else if (wr_idx_reg == `TDF_REG_FIRE) begin
        fire_control_config_reg <= wr_word;
      end else if (wr_idx_reg == `TDF_REG_TIMING) begin
        analog_timing_config_reg <= wr_word;
      end
    end
  end

  // Static front-end controls
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      comp_offset_mv_o <= 8'h00;
      width_edge_select_o <= 1'b0;
      mains_base_select_o <= 1'b0;
      finest_bin_select_o <= 1'b0;
      fire_idle_default_o <= 1'b0;
      analog_enable_o <= 1'b0;
    end else if (ce_i) begin
      comp_offset_mv_o <= offset_calc; // RL13
      width_edge_select_o <= analog_offset_config_reg[`TDF_WIDTH_EDGE_SELECT]; // RL14
      mains_base_select_o <= analog_timing_config_reg[`TDF_MAINS_BASE_SELECT]; // RL18
      finest_bin_select_o <= analog_timing_config_reg[`TDF_QUAD]; // RL20
      fire_idle_default_o <= analog_timing_config_reg[`TDF_FIRE_IDLE_DEFAULT]; // RL19
      analog_enable_o <= analog_timing_config_reg[`TDF_ANALOG_EN];
    end
  end

  // Measurement sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || (ce_i && soft_rst)) begin
      state_reg <= TDF_IDLE;
      kind_reg <= TDF_K_CAL;
      wait_cnt_reg <= 24'h00_0000;
      hit_cnt_reg <= 3'h0;
      armed_reg <= 1'b0;
      alt_mode_reg <= 1'b0;
      dir_up_reg <= 1'b0;
      tmo_reg <= 1'b0;
    end else if (ce_i) begin
      if (cmd_valid && op == `TDF_OP_INIT) begin
        armed_reg <= 1'b1; // RL6
      end
      case (state_reg)
        TDF_IDLE: begin
          if (start_cal || start_temp || start_tof) begin
            state_reg <= TDF_SETTLE;
            wait_cnt_reg <= settle_cyc; // RL17
            hit_cnt_reg <= 3'h0;
            tmo_reg <= 1'b0;
            kind_reg <= start_cal ? TDF_K_CAL : (start_temp ? TDF_K_TEMP : TDF_K_TOF);
            if (start_cal || start_temp) begin
              alt_mode_reg <= 1'b0;
            end
            if (start_tof && op == `TDF_OP_TOF_ALT) begin
              alt_mode_reg <= 1'b1; // RL7
              dir_up_reg <= first_up; // RL12
            end
          end
        end
        TDF_SETTLE: begin
          if (wait_cnt_reg != 24'h00_0000) begin
            wait_cnt_reg <= wait_cnt_reg - 24'h00_0001;
          end else if (kind_reg == TDF_K_TOF && charge_cyc != 24'h00_0000) begin
            state_reg <= TDF_CHARGE; // RL15
            wait_cnt_reg <= charge_cyc;
          end else begin
            state_reg <= TDF_MEASURE;
            wait_cnt_reg <= timo_cyc;
          end
        end
        TDF_CHARGE: begin
          if (wait_cnt_reg != 24'h00_0000) begin
            wait_cnt_reg <= wait_cnt_reg - 24'h00_0001;
          end else begin
            state_reg <= TDF_MEASURE;
            wait_cnt_reg <= timo_cyc;
          end
        end
        TDF_MEASURE: begin
          if (hit_valid_i) begin
            hit_cnt_reg <= hit_cnt_reg + 3'h1;
            if (hit_cnt_reg + 3'h1 == need_hits) begin
              state_reg <= TDF_DONE;
            end
          end else if (wait_cnt_reg == 24'h00_0000) begin
            state_reg <= TDF_DONE; // RL9
            tmo_reg <= 1'b1;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 24'h00_0001;
          end
        end
        TDF_DONE: begin
          state_reg <= TDF_IDLE;
          if (kind_reg == TDF_K_TOF) begin
            armed_reg <= 1'b0; // RL6
            dir_up_reg <= !dir_up_reg; // RL7
          end
        end
        default: state_reg <= TDF_IDLE;
      endcase
    end
  end

  // Result words and first-wave width; words hold until overwritten or cleared by reset or soft reset
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || (ce_i && soft_rst)) begin
      for (int i = 0; i < 4; i++) begin
        res_reg[i] <= 32'h0000_0000;
      end
      pw_reg <= 8'h00;
    end else if (ce_i && state_reg == TDF_MEASURE && hit_valid_i) begin
      if (kind_reg == TDF_K_TOF) begin
        res_reg[3] <= hit_data_i; // RL10
        pw_reg <= width_ratio_i; // RL11
      end else begin
        res_reg[hit_cnt_reg[1:0]] <= hit_data_i; // RL2 RL5 RL21
      end
    end
  end

  // Status word
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || (ce_i && soft_rst)) begin
      status_reg <= 16'h0000;
    end else if (ce_i) begin
      if (state_reg == TDF_IDLE && (start_cal || start_temp || start_tof)) begin
        status_reg <= 16'h0000;
      end else if (state_reg == TDF_DONE) begin
        status_reg[2:0] <= hit_cnt_reg;
        status_reg[`TDF_ST_DIR] <= dir_up_reg;
        status_reg[`TDF_ST_TOF_TMO] <= tmo_reg && kind_reg == TDF_K_TOF; // RL9
        status_reg[`TDF_ST_TEMP_TMO] <= tmo_reg && kind_reg == TDF_K_TEMP; // RL4
        status_reg[`TDF_ST_CAL_TMO] <= tmo_reg && kind_reg == TDF_K_CAL; // RL4
      end
    end
  end

  // Read answers
  always_comb begin
    bus.tx_load = 1'b0;
    bus.tx_word = 32'h0000_0000;
    if (cmd_valid) begin
      if (op[7:2] == `TDF_OP_RD_RES) begin
        bus.tx_load = 1'b1;
        bus.tx_word = res_reg[op[1:0]]; // RL5
      end else if (op == `TDF_OP_RD_STAT) begin
        bus.tx_load = 1'b1;
        bus.tx_word = {16'h0000, status_reg}; // RL4
      end else if (op == `TDF_OP_RD_PW) begin
        bus.tx_load = 1'b1;
        bus.tx_word = {24'h00_0000, pw_reg}; // RL11
      end
    end
  end

  // Interrupt line; a new completion wins over the release by a command
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_line_low_o <= 1'b1;
    end else if (ce_i) begin
      if (irq_set) begin
        irq_line_low_o <= 1'b0; // RL1 RL3
      end else if (cmd_valid) begin
        irq_line_low_o <= 1'b1;
      end
    end
  end

  // Fire enables follow the flight direction while measuring
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      fire_up_o <= 1'b0;
      fire_down_o <= 1'b0;
    end else if (ce_i) begin
      fire_up_o <= state_reg == TDF_MEASURE && kind_reg == TDF_K_TOF && dir_up_reg; // RL7
      fire_down_o <= state_reg == TDF_MEASURE && kind_reg == TDF_K_TOF && !dir_up_reg;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_irq_on_done;
    ce_i && ev_alu && int_mask[`TDF_INT_ALU] |=> !irq_line_low_o;
  endproperty
  a_irq_on_done: assert property (p_irq_on_done) else $error("irq not low"); // RL1

  property p_irq_release;
    ce_i && cmd_valid && !irq_set && !soft_rst |=> irq_line_low_o;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq not released"); // RL3

  property p_tof_needs_arm;
    ce_i && cmd_valid && op == `TDF_OP_TOF_ALT && !armed_reg && state_reg == TDF_IDLE
      |=> state_reg == TDF_IDLE;
  endproperty
  a_tof_needs_arm: assert property (p_tof_needs_arm) else $error("flight unarmed"); // RL6

  property p_alternate;
    ce_i && state_reg == TDF_DONE && kind_reg == TDF_K_TOF ##1 1'b1
      |-> dir_up_reg != $past(dir_up_reg);
  endproperty
  a_alternate: assert property (p_alternate) else $error("no alternation"); // RL7

  property p_tof_timeout;
    ce_i && ev_tmo && kind_reg == TDF_K_TOF |=> status_reg[`TDF_ST_TOF_TMO];
  endproperty
  a_tof_timeout: assert property (p_tof_timeout) else $error("timeout not flagged"); // RL9

  property p_tof_result;
    ce_i && state_reg == TDF_MEASURE && kind_reg == TDF_K_TOF && hit_valid_i
      |=> res_reg[3] == $past(hit_data_i);
  endproperty
  a_tof_result: assert property (p_tof_result) else $error("word three stale"); // RL10

  property p_down_first;
    ce_i && start_tof && op == `TDF_OP_TOF_ALT && !first_up |=> !dir_up_reg;
  endproperty
  a_down_first: assert property (p_down_first) else $error("not down first"); // RL12

  property p_charge_phase;
    ce_i && state_reg == TDF_SETTLE && wait_cnt_reg == 24'h00_0000 && kind_reg == TDF_K_TOF
      && charge_cyc != 24'h00_0000 |=> state_reg == TDF_CHARGE && wait_cnt_reg == $past(charge_cyc);
  endproperty
  a_charge_phase: assert property (p_charge_phase) else $error("charge skipped"); // RL15

  property p_offset;
    ce_i ##1 ce_i && $stable(analog_offset_config_reg) && !analog_offset_config_reg[`TDF_NEG_RNG]
      && analog_offset_config_reg[`TDF_POS_RNG]
      |=> comp_offset_mv_o == $past(offset_calc, 2) && comp_offset_mv_o[7] == 1'b0
        || analog_offset_config_reg[`TDF_COMPARATOR_OFFSET_CODE_MSB];
  endproperty
  a_offset: assert property (p_offset) else $error("offset wrong"); // RL13
endmodule : tdf_flow_core

// file: design/tdf_flow_core_end.sv
/*
  Empty companion of the command core; holds no logic.
  Assumes nothing of its surroundings.
*/

// file: testbench/tdf_host_model.sv
/*
  Host model: frames bytes onto the core's 4-wire serial port.
  Assumes ref_clk_i is the core clock; pins change on its falling edge.
*/
`timescale 1ns/10ps
module tdf_host_model (
  input wire logic ref_clk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic ssn_o,
  output logic mosi_o
);
  initial begin
    sclk_o = 1'b0;
    ssn_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Sends nbits of tx from bit 39 down; rx keeps the last 32 bits seen
  task automatic frame(input logic [39:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge ref_clk_i);
    ssn_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[39 - i];
      repeat (3) @(negedge ref_clk_i);
      sclk_o = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      rx = {rx[30:0], miso_i};
      sclk_o = 1'b0;
      repeat (3) @(negedge ref_clk_i);
    end
    ssn_o = 1'b1;
    // Released data line must not keep its last level
    mosi_o = ~mosi_o;
    repeat (4) @(negedge ref_clk_i);
  endtask : frame
endmodule : tdf_host_model

// file: testbench/tdc_measurement_flow_test.sv
/*
  Self-checking bench of the flow-meter TDC command core.
  Assumes the host model above and small timing parameters.
*/
`timescale 1ns/10ps
module tdc_measurement_flow_test;
  logic ref_clk_i, nrst_i, sclk, ssn, mosi, miso, hit_valid_i, irq_line_low;
  logic [31:0] hit_data_i, rd;
  logic [7:0] width_ratio_i, comparator_offset_code_mv;
  logic fire_up, fire_down, idle_def, ana_en, edge_sel, mains, quad, ce;
  int err_count, comparisons, n;

  tdf_flow_core #(.SETTLE_UNIT_CYC(4), .CHARGE_UNIT_CYC(3), .TIMO_UNIT_CYC(20)) i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce), .spi_sclk_i(sclk),
    .spi_ssn_i(ssn), .spi_mosi_i(mosi), .spi_miso_o(miso), .hit_valid_i(hit_valid_i),
    .hit_data_i(hit_data_i), .width_ratio_i(width_ratio_i),
    .irq_line_low_o(irq_line_low), .fire_up_o(fire_up), .fire_down_o(fire_down),
    .fire_idle_default_o(idle_def), .analog_enable_o(ana_en), .comp_offset_mv_o(comparator_offset_code_mv),
    .width_edge_select_o(edge_sel), .mains_base_select_o(mains),
    .finest_bin_select_o(quad));

  tdf_host_model i_host (.ref_clk_i(ref_clk_i), .miso_i(miso), .sclk_o(sclk),
    .ssn_o(ssn), .mosi_o(mosi));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    i_host.frame({5'h10, idx, d}, 40, rd);
  endtask : wr

  task automatic cmd(input logic [7:0] op);
    i_host.frame({op, 32'h0}, 8, rd);
  endtask : cmd

  task automatic rdw(input logic [7:0] op);
    i_host.frame({op, 32'h0}, 40, rd);
  endtask : rdw

  task automatic hit(input logic [31:0] d);
    hit_data_i = d;
    hit_valid_i = 1'b1;
    @(negedge ref_clk_i);
    hit_valid_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask : hit

  // Bounded wait for the interrupt line, then for a fire output
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq_line_low !== 1'b0 && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("irq line", 32'h0, {31'h0, irq_line_low});
    if (irq_line_low !== 1'b0) wrap_up();
  endtask : wait_irq

  task automatic wait_fire;
    n = 0;
    while (fire_up !== 1'b1 && fire_down !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("fire wait", 32'h1, {31'h0, n < 200});
    if (n >= 200) wrap_up();
  endtask : wait_fire

  task automatic t_config;
    wr(3'h4, 32'h0000_4A00);
    chk("offset pos", 32'h1E, {24'h0, comparator_offset_code_mv});
    chk("width edge", 32'h0, {31'h0, edge_sel});
    wr(3'h4, 32'h0000_2A00);
    chk("offset neg", 32'hF6, {24'h0, comparator_offset_code_mv});
    wr(3'h5, 32'h4000_0000);
    wr(3'h6, 32'h80F6_6800);
    wr(3'h3, 32'h0000_0000);
    chk("analog en", 32'h1, {31'h0, ana_en});
    chk("fire idle", 32'h1, {31'h0, idle_def});
    chk("finest bin", 32'h1, {31'h0, quad});
    chk("mains base", 32'h0, {31'h0, mains});
    $display("config test done");
  endtask : t_config

  task automatic t_cal;
    cmd(8'h03);
    repeat (30) @(negedge ref_clk_i);
    hit(32'h0001_2345);
    wait_irq(400);
    rdw(8'hB0);
    chk("cal word 0", 32'h0001_2345, rd);
    $display("calibration test done");
  endtask : t_cal

  task automatic t_temp;
    cmd(8'h02);
    repeat (30) @(negedge ref_clk_i);
    for (int i = 0; i < 4; i++) hit(32'h100 + i);
    wait_irq(400);
    rdw(8'hB4);
    chk("temp status", 32'h0, rd & 32'h1E00);
    for (int i = 0; i < 4; i++) begin
      rdw(8'hB0 + i[7:0]);
      chk("temp word", 32'h100 + i, rd);
    end
    $display("temperature test done");
  endtask : t_temp

  task automatic t_tof;
    cmd(8'h05);
    repeat (60) @(negedge ref_clk_i);
    chk("unarmed fire", 32'h0, {30'h0, fire_up, fire_down});
    cmd(8'h70);
    cmd(8'h05);
    wait_fire();
    chk("first dir", 32'h1, {30'h0, fire_up, fire_down});
    chk("fire delay", 32'h1, {31'h0, n >= 11 && n <= 20});
    hit(32'h0000_CAFE);
    wait_irq(400);
    rdw(8'hB4);
    chk("tof status", 32'h0, rd & 32'h0600);
    rdw(8'hB3);
    chk("tof word 3", 32'h0000_CAFE, rd);
    rdw(8'hB8);
    chk("width ratio", 32'h40, rd);
    rdw(8'hB0);
    chk("word 0 kept", 32'h100, rd);
    cmd(8'h70);
    wait_fire();
    chk("second dir", 32'h2, {30'h0, fire_up, fire_down});
    wait_irq(3000);
    rdw(8'hB4);
    chk("timeout status", 32'h0200, rd & 32'h0600);
    $display("flight test done");
  endtask : t_tof

  // Frozen core ignores a soft reset frame; a running one obeys it
  task automatic t_ctrl;
    ce = 1'b0;
    cmd(8'h50);
    ce = 1'b1;
    chk("frozen cfg", 32'h1, {31'h0, ana_en});
    cmd(8'h50);
    chk("soft rst cfg", 32'h0, {31'h0, ana_en});
    rdw(8'hB3);
    chk("soft rst word", 32'h0, rd);
    $display("control test done");
  endtask : t_ctrl

  initial begin
    nrst_i = 1'b0;
    ce = 1'b1;
    hit_valid_i = 1'b0;
    hit_data_i = 32'h0;
    width_ratio_i = 8'h40;
    err_count = 0;
    comparisons = 0;
    repeat (16) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    @(negedge ref_clk_i);
    chk("irq after reset", 32'h1, {31'h0, irq_line_low});
    t_config();
    t_cal();
    t_temp();
    t_tof();
    t_ctrl();
    wrap_up();
  end
endmodule : tdc_measurement_flow_test
